/* src/pdr_defines.svh */
// Constants of the PCM decoder receive interface: offsets, fields, resets, timing
`ifndef PDR_DEFINES_SVH
`define PDR_DEFINES_SVH

// System clock and time figures
`define PDR_CLK_MHZ 250
`define PDR_LOCK_TIME_MS 20
`define PDR_LOCK_CYC (`PDR_LOCK_TIME_MS * 1000 * `PDR_CLK_MHZ)
`define PDR_LOSS_TIME_US 250
`define PDR_LOSS_CYC (`PDR_LOSS_TIME_US * `PDR_CLK_MHZ)

// Word and buffer shape
`define PDR_WORD_BITS 8
`define PDR_FIFO_DEPTH 16
`define PDR_SIG_BIT 4'h7
`define PDR_FIRST_BIT 4'h0

// Register byte offsets
`define PDR_CTRL_OFS 32'h0000_0000
`define PDR_STATUS_OFS 32'h0000_0004
`define PDR_RXDATA_OFS 32'h0000_0008

// CTRL fields and reset value
`define PDR_CTRL_EN 0
`define PDR_CTRL_CCS 1
`define PDR_CTRL_RST 2'h1

// STATUS fields
`define PDR_ST_LOCKED 0
`define PDR_ST_PDOWN 1
`define PDR_ST_SIGA 2
`define PDR_ST_SIGB 3
`define PDR_ST_PINA 4
`define PDR_ST_PINB 5
`define PDR_ST_OVR 6
`define PDR_ST_NEMPTY 7
`define PDR_ST_SENSE 8

// RXDATA valid flag
`define PDR_RX_VALID 8

`endif

/* src/pdr_pkg.sv */
// Types shared by the PCM decoder receive interface
`default_nettype none
package pdr_pkg;
  typedef enum logic [1:0] {
    PDR_ST_DOWN = 2'b00,
    PDR_ST_LOCKING = 2'b01,
    PDR_ST_LOCKED = 2'b10
  } pdr_lock_e;

  typedef enum logic [1:0] {
    PDR_SENSE_TRUE = 2'b00,
    PDR_SENSE_INV = 2'b01,
    PDR_SENSE_TEST = 2'b10
  } pdr_sense_e;
endpackage : pdr_pkg
`default_nettype wire

/* src/pdr_fifo_if.sv */
// Valid/ready word channel through the receive buffer
`default_nettype none
interface pdr_fifo_if #(parameter int W = 8);
  logic [W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [W-1:0] rdata;
  logic rvalid;
  logic rready;

  modport prod (output wdata, output wvalid, input wready);
  modport buff (input wdata, input wvalid, output wready,
                output rdata, output rvalid, input rready);
  modport cons (input rdata, input rvalid, output rready);
endinterface : pdr_fifo_if
`default_nettype wire

/* src/pdr_sync.sv */
// Two-flop synchroniser, one per bit
`default_nettype none
module pdr_sync #(parameter int W = 1)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic meta;
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        meta <= 1'b0;
        q[i] <= 1'b0;
      end
      else
      begin
        meta <= d[i];
        q[i] <= meta;
      end
    end
  end
endmodule : pdr_sync
`default_nettype wire

/* src/pdr_fifo.sv */
// Word FIFO with valid/ready on both sides
`default_nettype none
module pdr_fifo #(parameter int W = 8, parameter int D = 16)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling and draining sides
  pdr_fifo_if.buff ch
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;

  assign empty = (wp == rp);
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign ch.wready = !full;
  assign ch.rvalid = !empty;
  assign ch.rdata = mem[rp[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (ch.wvalid && !full)
      mem[wp[AW-1:0]] <= ch.wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (ch.wvalid && !full)
        wp <= wp + 1'b1;
      if (ch.rready && !empty)
        rp <= rp + 1'b1;
    end
  end
endmodule : pdr_fifo
`default_nettype wire

/* src/pdr_top.sv */
// PCM decoder serial receive interface with signaling outputs and AHB-Lite registers
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`include "pdr_defines.svh"
`default_nettype none
module pdr_top #(
  parameter int unsigned LOCK_CYC = `PDR_LOCK_CYC,
  parameter int unsigned LOSS_CYC = `PDR_LOSS_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // PCM highway
  input wire logic strobe,
  input wire logic shift_clk,
  input wire logic pcm_in,
  input wire logic ab_sel,
  input wire logic ab_in,
  // Three-level output-sense pin, as two comparator levels
  input wire logic sense_vdd,
  input wire logic sense_vss,
  // Analog stage levels shown on the pins in test mode
  input wire logic sh_level,
  input wire logic filt_level,
  // Open-drain signaling pins
  input wire logic sig_a_in,
  output logic sig_a_out,
  output logic sig_a_oe,
  input wire logic sig_b_in,
  output logic sig_b_out,
  output logic sig_b_oe,
  // Conversion stage
  output logic [`PDR_WORD_BITS-1:0] conv_word,
  output logic conv_stb,
  output logic power_down,
  output logic test_mode
);
  localparam int WB = `PDR_WORD_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection

  logic [8:0] pins_s;
  logic str_s, sck_s, pcm_s, sel_s, abin_s, svdd_s, svss_s, pina_s, pinb_s;
  logic str_d, sck_d, sel_d;
  logic str_rise, str_fall, sck_fall, sel_rise, sel_fall;

  pdr_sync #(.W(9)) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .d({strobe, shift_clk, pcm_in, ab_sel, ab_in, sense_vdd, sense_vss, sig_a_in, sig_b_in}),
    .q(pins_s)
  );

  assign {str_s, sck_s, pcm_s, sel_s, abin_s, svdd_s, svss_s, pina_s, pinb_s} = pins_s;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      str_d <= 1'b0;
      sck_d <= 1'b0;
      sel_d <= 1'b0;
    end
    else
    begin
      str_d <= str_s;
      sck_d <= sck_s;
      sel_d <= sel_s;
    end
  end

  assign str_rise = str_s && !str_d;
  assign str_fall = !str_s && str_d;
  assign sck_fall = !sck_s && sck_d;
  assign sel_rise = sel_s && !sel_d;
  assign sel_fall = !sel_s && sel_d;

  ////////////////////////////////////////////////////////////////////////////
  // Control register and sense decode

  logic [1:0] ctrl;
  logic en, ccs;
  pdr_pkg::pdr_sense_e sense;

  assign en = ctrl[`PDR_CTRL_EN];
  assign ccs = ctrl[`PDR_CTRL_CCS];

  always_comb
  begin
    if (svdd_s)
      sense = pdr_pkg::PDR_SENSE_TEST;
    else if (svss_s)
      sense = pdr_pkg::PDR_SENSE_INV;
    else
      sense = pdr_pkg::PDR_SENSE_TRUE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe-locked timing: gap watchdog and lock counter

  pdr_pkg::pdr_lock_e state, next_state;
  logic [31:0] gap_cnt;
  logic [31:0] lock_cnt;
  logic lost;
  logic locked;

  // A stopped strobe or a disabled block both count as loss of reference
  assign lost = !en || (!str_rise && gap_cnt >= LOSS_CYC);
  assign locked = (state == pdr_pkg::PDR_ST_LOCKED);

  always_comb
  begin
    next_state = state;
    case (state)
      pdr_pkg::PDR_ST_DOWN:
        if (en && str_rise)
          next_state = pdr_pkg::PDR_ST_LOCKING;
      pdr_pkg::PDR_ST_LOCKING:
        if (lost)
          next_state = pdr_pkg::PDR_ST_DOWN;
        else if (lock_cnt >= LOCK_CYC - 1)
          next_state = pdr_pkg::PDR_ST_LOCKED;
      pdr_pkg::PDR_ST_LOCKED:
        if (lost)
          next_state = pdr_pkg::PDR_ST_DOWN;
      default:
        next_state = pdr_pkg::PDR_ST_DOWN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state <= pdr_pkg::PDR_ST_DOWN;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      gap_cnt <= '0;
    else if (str_rise)
      gap_cnt <= '0;
    else if (gap_cnt != 32'hFFFF_FFFF)
      gap_cnt <= gap_cnt + 32'h1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lock_cnt <= '0;
    else if (state != pdr_pkg::PDR_ST_LOCKING)
      lock_cnt <= '0;
    else
      lock_cnt <= lock_cnt + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial word capture

  logic [WB-1:0] shreg;
  logic [3:0] bit_cnt;
  logic shift_on;
  logic a_cap, b_cap;
  logic frame_done;

  assign frame_done = str_fall && shift_on && (bit_cnt == 4'(WB)) && locked;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_on <= 1'b0;
      bit_cnt <= '0;
      shreg <= '0;
      a_cap <= 1'b0;
      b_cap <= 1'b0;
    end
    else if (str_rise)
    begin
      shift_on <= 1'b1;
      bit_cnt <= '0;
    end
    else if (str_fall)
      shift_on <= 1'b0;
    else if (shift_on && str_s && sck_fall && bit_cnt < 4'(WB))
    begin
      shreg <= {shreg[WB-2:0], pcm_s};
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == `PDR_FIRST_BIT)
        a_cap <= abin_s;
      if (bit_cnt == `PDR_SIG_BIT)
        b_cap <= abin_s;
    end
  end

  // Parallel hand-over to the conversion stage
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_word <= '0;
      conv_stb <= 1'b0;
    end
    else
    begin
      conv_stb <= frame_done;
      if (frame_done)
        conv_word <= shreg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signaling routing

  logic pend_a, pend_b;
  logic sig_a, sig_b;

  // Select edges wait for the word's end so the routed bit is the fresh one
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
      sig_a <= 1'b0;
      sig_b <= 1'b0;
    end
    else
    begin
      if (sel_rise)
        pend_a <= 1'b1;
      else if (frame_done)
        pend_a <= 1'b0;
      if (sel_fall)
        pend_b <= 1'b1;
      else if (frame_done)
        pend_b <= 1'b0;
      if (frame_done && ccs)
      begin
        sig_a <= a_cap;
        sig_b <= b_cap;
      end
      else if (frame_done)
      begin
        if (pend_a)
          sig_a <= shreg[0];
        if (pend_b)
          sig_b <= shreg[0];
      end
    end
  end

  // Open drain: only ever pull low, release for a high level
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sig_a_out <= 1'b0;
      sig_b_out <= 1'b0;
      sig_a_oe <= 1'b0;
      sig_b_oe <= 1'b0;
      power_down <= 1'b1;
      test_mode <= 1'b0;
    end
    else
    begin
      sig_a_out <= 1'b0;
      sig_b_out <= 1'b0;
      power_down <= (state == pdr_pkg::PDR_ST_DOWN);
      test_mode <= (sense == pdr_pkg::PDR_SENSE_TEST);
      case (sense)
        pdr_pkg::PDR_SENSE_TEST:
        begin
          sig_a_oe <= !filt_level;
          sig_b_oe <= !sh_level;
        end
        pdr_pkg::PDR_SENSE_INV:
        begin
          sig_a_oe <= locked && sig_a;
          sig_b_oe <= locked && sig_b;
        end
        default:
        begin
          sig_a_oe <= locked && !sig_a;
          sig_b_oe <= locked && !sig_b;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer

  pdr_fifo_if #(.W(WB)) fch ();
  logic ovr;
  logic pop;

  pdr_fifo #(.W(WB), .D(`PDR_FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .ch(fch.buff)
  );

  // One staging word; a new frame while it still waits is an overrun
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fch.wvalid <= 1'b0;
      fch.wdata <= '0;
    end
    else if (frame_done)
    begin
      fch.wvalid <= 1'b1;
      fch.wdata <= shreg;
    end
    else if (fch.wready)
      fch.wvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  logic ap;
  logic dp_wr;
  logic [31:0] dp_addr;
  logic [31:0] rd_mux;

  assign ap = hsel && htrans[1] && hready;
  assign pop = ap && !hwrite && (haddr == `PDR_RXDATA_OFS);
  assign fch.rready = pop;

  always_comb
  begin
    rd_mux = '0;
    case (haddr)
      `PDR_CTRL_OFS:
        rd_mux[1:0] = ctrl;
      `PDR_STATUS_OFS:
      begin
        rd_mux[`PDR_ST_LOCKED] = locked;
        rd_mux[`PDR_ST_PDOWN] = (state == pdr_pkg::PDR_ST_DOWN);
        rd_mux[`PDR_ST_SIGA] = sig_a;
        rd_mux[`PDR_ST_SIGB] = sig_b;
        rd_mux[`PDR_ST_PINA] = pina_s;
        rd_mux[`PDR_ST_PINB] = pinb_s;
        rd_mux[`PDR_ST_OVR] = ovr;
        rd_mux[`PDR_ST_NEMPTY] = fch.rvalid;
        rd_mux[`PDR_ST_SENSE+1:`PDR_ST_SENSE] = sense;
      end
      `PDR_RXDATA_OFS:
      begin
        rd_mux[WB-1:0] = fch.rvalid ? fch.rdata : '0;
        rd_mux[`PDR_RX_VALID] = fch.rvalid;
      end
      default:
        rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dp_wr <= 1'b0;
      dp_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_wr <= ap && hwrite;
      if (ap)
        dp_addr <= haddr;
      if (ap && !hwrite)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ctrl <= `PDR_CTRL_RST;
    else if (dp_wr && dp_addr == `PDR_CTRL_OFS)
      ctrl <= hwdata[1:0];
  end

  // Overrun is sticky, write one to clear; a new overrun wins over the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ovr <= 1'b0;
    else if (frame_done && fch.wvalid && !fch.wready)
      ovr <= 1'b1;
    else if (dp_wr && dp_addr == `PDR_STATUS_OFS && hwdata[`PDR_ST_OVR])
      ovr <= 1'b0;
  end
endmodule : pdr_top
`default_nettype wire

/* test/pdr_top_sva.sv */
// Port-level checker of the PCM receive block
`default_nettype none
module pdr_top_sva #(
  parameter int unsigned LOCK_CYC = 64,
  parameter int unsigned LOSS_CYC = 2000
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Highway and levels
  input wire logic strobe,
  input wire logic sh_level,
  input wire logic filt_level,
  // Signaling pins and conversion side
  input wire logic sig_a_out,
  input wire logic sig_a_oe,
  input wire logic sig_b_out,
  input wire logic sig_b_oe,
  input wire logic conv_stb,
  input wire logic power_down,
  input wire logic test_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // Strobe low time, and time out of power-down
  int unsigned lo_cnt;
  int unsigned up_cnt;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      lo_cnt <= 32'h0;
    else
      lo_cnt <= strobe ? 32'h0 : lo_cnt + 32'h1;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      up_cnt <= 32'h0;
    else
      up_cnt <= power_down ? 32'h0 : up_cnt + 32'h1;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_OD_LOW: assert property (!sig_a_out && !sig_b_out)
    else $error("signaling pin driven high");
  // One extra cycle allowed; the mode flags and pins are registered together in the same cycle
  AST_IDLE_OE: assert property (
    power_down && $past(power_down) && !test_mode && !$past(test_mode)
    |-> !sig_a_oe && !sig_b_oe) else $error("signaling not idle while down");
  AST_TEST_PINS: assert property (
    (test_mode && $stable(filt_level) && $stable(sh_level)) [*3]
    |-> sig_a_oe == !filt_level && sig_b_oe == !sh_level) else $error("test pins wrong");
  AST_WORD_AT_FALL: assert property (
    conv_stb |-> lo_cnt >= 32'h2 && lo_cnt <= 32'h8) else $error("word not at strobe fall");
  AST_WORD_PULSE: assert property (conv_stb |=> !conv_stb)
    else $error("word pulse too long");
  AST_LOSS_DOWN: assert property (
    lo_cnt > LOSS_CYC + 4 |-> power_down) else $error("no power-down");
  AST_LOCK_TIME: assert property (
    conv_stb |-> up_cnt >= LOCK_CYC - 1) else $error("word before lock");
  AST_HRESP_OKAY: assert property (!hresp) else $error("error response");
  AST_READY: assert property (!$past(rst) |-> hreadyout) else $error("wait state");
endmodule : pdr_top_sva
bind pdr_top pdr_top_sva #(.LOCK_CYC(LOCK_CYC), .LOSS_CYC(LOSS_CYC)) u_sva (
  .sys_clk(sys_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .strobe(strobe),
  .sh_level(sh_level), .filt_level(filt_level), .sig_a_out(sig_a_out),
  .sig_a_oe(sig_a_oe), .sig_b_out(sig_b_out), .sig_b_oe(sig_b_oe),
  .conv_stb(conv_stb), .power_down(power_down), .test_mode(test_mode));
`default_nettype wire

/* test/pdr_link_model.sv */
// Far-end highway transmitter model
`default_nettype none
module pdr_link_model
(
  // Highway lines
  output var logic strobe,
  output var logic shift_clk,
  output var logic pcm_in,
  output var logic ab_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    strobe = 1'b0;
    shift_clk = 1'b0;
    pcm_in = 1'b0;
    ab_in = 1'b0;
  end
  // Clock stands low between frames; released data lines flip so no stale value is read
  task automatic frame(input logic [7:0] w, input int n, input logic a, input logic b);
    #1.3 strobe = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      #16 shift_clk = 1'b1;
      pcm_in = w[7-i];
      ab_in = (i == 0) ? a : (i == 7) ? b : !ab_in;
      #32 shift_clk = 1'b0;
      #16;
    end
    strobe = 1'b0;
    pcm_in = !pcm_in;
    ab_in = !ab_in;
  endtask : frame
endmodule : pdr_link_model
`default_nettype wire

/* test/pdr_top_bench.sv */
// Self-checking bench of the PCM receive block
`include "pdr_defines.svh"
`default_nettype none
module pdr_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned LK = 64;
  localparam int unsigned LS = 2000;
  localparam logic [31:0] ST = `PDR_STATUS_OFS;
  localparam logic [31:0] RX = `PDR_RXDATA_OFS;
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ab_sel = 1'b0;
  logic sense_vdd = 1'b0, sense_vss = 1'b0, sh_level = 1'b0, filt_level = 1'b0;
  logic ea = 1'b0, eb = 1'b0, got = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rq;
  logic [7:0] conv_word;
  logic hreadyout, hresp, conv_stb, power_down, test_mode;
  logic sig_a_out, sig_a_oe, sig_b_out, sig_b_oe;
  wire logic strobe, shift_clk, pcm_in, ab_in;
  // Pull-ups on the open-drain signaling pins
  wire logic sig_a_in = (sig_a_oe === 1'b1) ? sig_a_out : 1'b1;
  wire logic sig_b_in = (sig_b_oe === 1'b1) ? sig_b_out : 1'b1;
  int miscompares = 0, n_compared = 0, seed = 30, cyc = 0;
  logic [7:0] q[$];
  pdr_link_model link (.strobe(strobe), .shift_clk(shift_clk), .pcm_in(pcm_in), .ab_in(ab_in));
  pdr_top #(.LOCK_CYC(LK), .LOSS_CYC(LS)) dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .strobe(strobe), .shift_clk(shift_clk),
    .pcm_in(pcm_in), .ab_sel(ab_sel), .ab_in(ab_in), .sense_vdd(sense_vdd),
    .sense_vss(sense_vss), .sh_level(sh_level), .filt_level(filt_level),
    .sig_a_in(sig_a_in), .sig_a_out(sig_a_out), .sig_a_oe(sig_a_oe), .sig_b_in(sig_b_in),
    .sig_b_out(sig_b_out), .sig_b_oe(sig_b_oe), .conv_word(conv_word), .conv_stb(conv_stb),
    .power_down(power_down), .test_mode(test_mode));
  ////////////////////////////////////////
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Single transfer; waits on hready in both phases, no latency assumed
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    ahb(1'b0, a, 32'h0, rq);
    check(nm, rq & m, e);
  endtask : rdc
  function automatic logic oe_of(input logic v);
    return sense_vss ? v : !v;
  endfunction : oe_of
  task automatic frm(input logic [7:0] w, input int n, input logic a, input logic b);
    got = 1'b0;
    link.frame(w, n, a, b);
    for (int k = 0; k < 12 && !got; k++)
    begin
      @(posedge sys_clk);
      got = (conv_stb === 1'b1);
    end
    repeat (3) @(posedge sys_clk);
  endtask : frm
  // Random words with random select edges, or common-channel bits
  task automatic burst(input int cnt, input logic ccs, input logic keep);
    logic [7:0] w;
    logic a, b;
    for (int i = 0; i < cnt; i++)
    begin
      w = 8'($random(seed));
      a = 1'($random(seed));
      b = 1'($random(seed));
      if (!ccs && ($random(seed) % 2))
      begin
        @(posedge sys_clk);
        ab_sel <= !ab_sel;
        if (ab_sel)
          eb = w[0];
        else
          ea = w[0];
      end
      if (ccs)
        {ea, eb} = {a, b};
      frm(w, 8, a, b);
      check("stb", got, 1'b1);
      check("word", conv_word, w);
      check("oe_a", sig_a_oe, oe_of(ea));
      check("oe_b", sig_b_oe, oe_of(eb));
      rdc(ST, 32'h3C, {!oe_of(eb), !oe_of(ea), eb, ea, 2'h0}, "st_sig");
      if (keep)
        q.push_back(w);
      else
        rdc(RX, 32'h1FF, {23'h0, 1'b1, w}, "rxdata");
    end
  endtask : burst
  ////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(`PDR_CTRL_OFS, 32'h3, 32'h1, "ctrl");
    rdc(ST, 32'h3FF, 32'h32, "status");
    rdc(32'hC, 32'hFFFFFFFF, 32'h0, "unmapped");
    frm(8'hA5, 7, 1'b0, 1'b0);
    check("lock", power_down, 1'b0);
    frm(8'h3C, 7, 1'b0, 1'b0);
    check("short", got, 1'b0);
    rdc(ST, 32'h3, 32'h1, "locked");
    burst(16, 1'b0, 1'b0);
    sense_vss <= 1'b1;
    burst(8, 1'b0, 1'b0);
    rdc(ST, 32'h300, 32'h100, "sense");
    burst(18, 1'b0, 1'b1);
    // The overrunning frame replaces the word still waiting in staging
    q.delete(16);
    rdc(ST, 32'hC0, 32'hC0, "ovr");
    for (int k = 0; k <= `PDR_FIFO_DEPTH; k++)
      rdc(RX, 32'h1FF, {23'h0, 1'b1, q[k]}, "fifo");
    rdc(RX, 32'h1FF, 32'h0, "empty");
    ahb(1'b1, ST, 32'h40, rq);
    rdc(ST, 32'hC0, 32'h0, "w1c");
    ahb(1'b1, `PDR_CTRL_OFS, 32'h3, rq);
    burst(8, 1'b1, 1'b0);
    ahb(1'b1, `PDR_CTRL_OFS, 32'h1, rq);
    sense_vdd <= 1'b1;
    repeat (8)
    begin
      sh_level <= 1'($random(seed));
      filt_level <= 1'($random(seed));
      repeat (6) @(posedge sys_clk);
      check("test_a", sig_a_oe, !filt_level);
      check("test_b", sig_b_oe, !sh_level);
    end
    check("test", test_mode, 1'b1);
    sense_vdd <= 1'b0;
    sense_vss <= 1'b0;
    repeat (LS + 100) @(posedge sys_clk);
    rdc(ST, 32'h33, 32'h32, "down");
    frm(8'h00, 7, 1'b0, 1'b0);
    check("relock", power_down, 1'b0);
    frm(8'h81, 8, 1'b0, 1'b0);
    check("word2", conv_word, 8'h81);
    rdc(RX, 32'h1FF, 32'h181, "rx2");
    // Clearing the enable drops the loop at once
    ahb(1'b1, `PDR_CTRL_OFS, 32'h0, rq);
    rdc(ST, 32'h3, 32'h2, "disable");
    complete_run();
  end
endmodule : pdr_top_bench
`default_nettype wire
